// ==== src/clock_mode_pkg.sv ====
// clock mode controller constants: timing, pll setup and state encoding
// assumes a single 125 MHz reference-derived control clock
package clock_mode_pkg;
  // ==========================================================
  // clock rates
  localparam int unsigned CTRL_CLK_MHZ = 125; // control clock rate
  localparam int unsigned REF_CLK_MHZ = 25; // reference clock input
  localparam int unsigned CORE_CLK_MHZ = 400; // default core clock
  // ==========================================================
  // pll default configuration
  localparam int unsigned PLL_MULT_W = 8; // multiplier field width
  localparam logic [PLL_MULT_W-1:0] PLL_MULT_RST =
    PLL_MULT_W'(CORE_CLK_MHZ / REF_CLK_MHZ); // 400 / 25
  // ==========================================================
  // lock settle time
  localparam int unsigned LOCK_SETTLE_NS = 1000; // lock must hold this long
  localparam int unsigned LOCK_SETTLE_CYC =
    (LOCK_SETTLE_NS * CTRL_CLK_MHZ + 999) / 1000; // rounded up
  localparam int unsigned LOCK_CNT_W = 8; // settle counter width
  // ==========================================================
  // controller states
  typedef enum logic [1:0] {
    ST_REF,
    ST_PLL,
    ST_SLEEP_WAIT,
    ST_SLEEP
  } ctrl_state_t;
endpackage : clock_mode_pkg

// ==== src/clock_mode_sleep_controller.sv ====
// clock mode controller: pll switch-over, host port gating, sleep, safe mode
// assumes straps are stable from reset and all inputs sync to ref_clk
`timescale 1ns/1ps
`default_nettype none
module clock_mode_sleep_controller (
  input wire logic ref_clk, // control clock, 125 MHz
  input wire logic reset, // synchronous, active high
  input wire logic operating_strap, // 0 = normal operating mode
  input wire logic safe_operation_strap, // 1 = safe mode
  input wire logic host_sel, // 1 = pcie host, 0 = spi slave host
  input wire logic sleep_req, // level, high requests sleep
  input wire logic pll_lock, // raw lock indication
  input wire logic spi_slave_busy, // spi slave transaction pending
  input wire logic spi_master_busy, // spi master transaction pending
  input wire logic manual_pll_sel, // host override: 1 = pll clock
  output logic [clock_mode_pkg::PLL_MULT_W-1:0] pll_mult, // pll multiplier
  output logic pll_enable, // pll running
  output logic div_enable, // clock dividers running
  output logic core_sel_pll, // 1 = core on pll clock
  output logic core_clk_en, // core clock gate enable
  output logic pcie_clk_en, // pcie interface clock enable
  output logic spi_slave_clk_en, // spi slave clock enable
  output logic spi_master_clk_en, // spi master clock enable
  output logic pcie_host_active, // pcie chosen as host port
  output logic spi_host_active, // spi slave chosen as host port
  output logic lock_status, // qualified lock for host polling
  output logic sleep_active // device is asleep
);
  import clock_mode_pkg::*;
  // ==========================================================
  // straps captured after reset release
  logic safe_ff; // safe mode latched
  logic normal_ff; // normal mode latched
  logic strap_seen_ff; // straps captured once
  // take the strap levels on the first clock out of reset
  // a later change of strap has no effect until the next reset,
  // so a bouncing board jumper cannot flip the mode mid-run
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_seen_ff <= 1'b0;
      safe_ff <= 1'b0;
      normal_ff <= 1'b1;
    end else if (!strap_seen_ff) begin
      strap_seen_ff <= 1'b1;
      safe_ff <= safe_operation_strap;
      normal_ff <= ~operating_strap;
    end
  end
  // ==========================================================
  // lock qualification
  // a raw lock that chatters would otherwise switch the core early
  logic lock_ok; // lock held steady
  lock_qualifier #(
    .SETTLE(LOCK_SETTLE_CYC)
  ) u_lock (
    .ref_clk(ref_clk),
    .reset(reset),
    .pll_lock(pll_lock),
    .lock_ok(lock_ok)
  );
  // ==========================================================
  // state and registers
  ctrl_state_t state_ff, nxt_state; // controller state
  logic sel_pll_ff, nxt_sel_pll; // core clock source
  logic core_en_ff, pcie_en_ff, spis_en_ff, spim_en_ff; // gate enables
  logic pcie_act_ff, spi_act_ff; // host port flags
  logic lock_ff, sleep_ff; // status outputs
  // ==========================================================
  // decode
  // the automatic switch and the manual path exclude each other:
  // auto needs normal mode without safe, manual needs safe mode
  wire spi_idle = ~spi_slave_busy & ~spi_master_busy; // nothing pending
  wire auto_switch = normal_ff & ~safe_ff & lock_ok; // automatic pll switch
  wire manual_ok = safe_ff & strap_seen_ff; // manual path open
  wire man_sel = manual_pll_sel & lock_ok; // host command, lock-gated
  wire awake = (state_ff == ST_REF) || (state_ff == ST_PLL) ||
               (state_ff == ST_SLEEP_WAIT); // clocks still running
  wire pcie_want = safe_ff | host_sel; // pcie port clocked
  wire spi_want = safe_ff | ~host_sel; // spi slave clocked
  wire pcie_live = pcie_want; // pcie link kept alive in sleep
  // ==========================================================
  // next state
  // sleep is only entered through the drain state, so a pending spi
  // transfer never loses its clock half way through
  always_comb begin
    nxt_state = state_ff;
    nxt_sel_pll = sel_pll_ff;
    case (state_ff)
      // running from reference clock
      ST_REF: begin
        if (sleep_req && strap_seen_ff) begin
          nxt_state = ST_SLEEP_WAIT;
        end else if (auto_switch) begin
          nxt_state = ST_PLL;
          nxt_sel_pll = 1'b1;
        end else if (manual_ok && man_sel) begin
          nxt_state = ST_PLL;
          nxt_sel_pll = 1'b1;
        end
      end
      // running from pll clock
      ST_PLL: begin
        if (sleep_req) begin
          nxt_state = ST_SLEEP_WAIT;
        end else if (manual_ok && !manual_pll_sel) begin
          nxt_state = ST_REF; // host moves back by hand
          nxt_sel_pll = 1'b0;
        end
      end
      // waiting for spi traffic to drain
      ST_SLEEP_WAIT: begin
        if (!sleep_req) begin
          nxt_state = sel_pll_ff ? ST_PLL : ST_REF;
        end else if (spi_idle) begin
          nxt_state = ST_SLEEP;
        end
      end
      // asleep: source select held, core and spi gates closed
      ST_SLEEP: begin
        if (!sleep_req) begin
          nxt_state = sel_pll_ff ? ST_PLL : ST_REF;
        end
      end
      default: begin
        nxt_state = ST_REF;
        nxt_sel_pll = 1'b0;
      end
    endcase
  end
  // ==========================================================
  // next gate enables, seen from the next state
  wire nxt_awake = (nxt_state != ST_SLEEP); // clocks stay on
  wire nxt_core_en = nxt_awake;
  wire nxt_pcie_en = pcie_want & (nxt_awake | pcie_live);
  wire nxt_spis_en = spi_want & nxt_awake;
  wire nxt_spim_en = nxt_awake;
  // ==========================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= ST_REF;
      sel_pll_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sel_pll_ff <= nxt_sel_pll;
    end
  end
  // gate enable registers
  // the enables are taken from the next state, so they change on the
  // same edge as the state and leave the block straight from a flop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_en_ff <= 1'b1;
      pcie_en_ff <= 1'b0;
      spis_en_ff <= 1'b0;
      spim_en_ff <= 1'b1;
    end else begin
      core_en_ff <= nxt_core_en;
      pcie_en_ff <= nxt_pcie_en;
      spis_en_ff <= nxt_spis_en;
      spim_en_ff <= nxt_spim_en;
    end
  end
  // status registers
  // the host flags follow host_sel one edge late, like every output
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pcie_act_ff <= 1'b0;
      spi_act_ff <= 1'b0;
      lock_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else begin
      pcie_act_ff <= host_sel;
      spi_act_ff <= ~host_sel;
      lock_ff <= lock_ok;
      sleep_ff <= (nxt_state == ST_SLEEP);
    end
  end
  // ==========================================================
  // outputs
  logic [PLL_MULT_W-1:0] mult_ff; // pll multiplier register
  logic pll_en_ff, div_en_ff; // pll and dividers on
  // pll and dividers are never stopped, not even in sleep
  // keeping them alive costs some sleep power but lets the core clock
  // return on the edge after the sleep request is dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mult_ff <= PLL_MULT_RST;
      pll_en_ff <= 1'b1;
      div_en_ff <= 1'b1;
    end else begin
      mult_ff <= PLL_MULT_RST;
      pll_en_ff <= 1'b1;
      div_en_ff <= awake | 1'b1;
    end
  end
  assign pll_mult = mult_ff;
  assign pll_enable = pll_en_ff;
  assign div_enable = div_en_ff;
  assign core_sel_pll = sel_pll_ff;
  assign core_clk_en = core_en_ff;
  assign pcie_clk_en = pcie_en_ff;
  assign spi_slave_clk_en = spis_en_ff;
  assign spi_master_clk_en = spim_en_ff;
  assign pcie_host_active = pcie_act_ff;
  assign spi_host_active = spi_act_ff;
  assign lock_status = lock_ff;
  assign sleep_active = sleep_ff;
endmodule : clock_mode_sleep_controller
`default_nettype wire

// ==== src/lock_qualifier.sv ====
// lock qualifier: reports lock only after the raw indication held steady
// assumes pll_lock is synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module lock_qualifier #(
  parameter int unsigned SETTLE = clock_mode_pkg::LOCK_SETTLE_CYC // cycles of steady lock
) (
  input wire logic ref_clk, // control clock
  input wire logic reset, // synchronous, active high
  input wire logic pll_lock, // raw lock from the pll
  output logic lock_ok // qualified lock
);
  import clock_mode_pkg::*;
  // ==========================================================
  // settle counter
  logic [LOCK_CNT_W-1:0] cnt_ff; // cycles of continuous lock
  logic lock_ok_ff; // qualified lock register
  wire cnt_done = (cnt_ff >= LOCK_CNT_W'(SETTLE - 1)); // count reached
  // count while locked, restart on any loss of lock
  always_ff @(posedge ref_clk) begin
    if (reset || !pll_lock) begin
      cnt_ff <= '0;
      lock_ok_ff <= 1'b0;
    end else if (!cnt_done) begin
      cnt_ff <= cnt_ff + LOCK_CNT_W'(1);
    end else begin
      lock_ok_ff <= 1'b1;
    end
  end
  assign lock_ok = lock_ok_ff;
endmodule : lock_qualifier
`default_nettype wire

// ==== tb/clock_mode_checker_assertions.sv ====
// checker: port-level relations of the clock mode controller
// assumes it is bound to the controller top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module clock_mode_checker (
  input wire logic ref_clk, reset, operating_strap, safe_operation_strap, host_sel,
  input wire logic sleep_req, pll_lock, spi_slave_busy, spi_master_busy, manual_pll_sel,
  input wire logic [clock_mode_pkg::PLL_MULT_W-1:0] pll_mult,
  input wire logic pll_enable, div_enable, core_sel_pll, core_clk_en, pcie_clk_en,
  input wire logic spi_slave_clk_en, spi_master_clk_en, pcie_host_active, spi_host_active,
  input wire logic lock_status, sleep_active
);
  import clock_mode_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // sleep steps: idle request, then blocked by a busy interface
  sequence idle_req;
    sleep_req && !spi_slave_busy && !spi_master_busy;
  endsequence
  sequence busy_wait;
    (spi_slave_busy || spi_master_busy) && !sleep_active;
  endsequence
  chk_mult_fixed: assert property (pll_mult == PLL_MULT_RST)
    else $error("pll multiplier off default");
  chk_pll_running: assert property (pll_enable && div_enable)
    else $error("pll or dividers stopped");
  chk_lock_first: assert property ($rose(core_sel_pll) |-> lock_status)
    else $error("pll clock chosen without lock");
  chk_no_fallback: assert property (core_sel_pll && !safe_operation_strap |=> core_sel_pll)
    else $error("core fell back to reference");
  // the host flags take host_sel on the first edge after release
  chk_host_flags: assert property (
    !reset && host_sel |=> pcie_host_active && !spi_host_active)
    else $error("pcie not flagged as host");
  chk_gate_spi: assert property (!safe_operation_strap && host_sel |=> !spi_slave_clk_en)
    else $error("unused spi slave clock on");
  chk_gate_pcie: assert property (!safe_operation_strap && !host_sel |=> !pcie_clk_en)
    else $error("unused pcie clock on");
  chk_safe_both: assert property (
    (safe_operation_strap && !sleep_req) [*3] |=> pcie_clk_en && spi_slave_clk_en)
    else $error("safe mode gated a host port");
  chk_busy_hold: assert property (busy_wait |=> !sleep_active)
    else $error("slept with busy interface");
  chk_sleep_entry: assert property (
    idle_req [*4] |-> sleep_active && !core_clk_en && !spi_master_clk_en && !spi_slave_clk_en)
    else $error("sleep not entered");
  chk_sleep_exit: assert property (
    sleep_active && !sleep_req |=> !sleep_active && core_clk_en && spi_master_clk_en)
    else $error("clocks not restored on wake");
  chk_safe_manual: assert property (
    (safe_operation_strap && !manual_pll_sel && !sleep_active) [*3] |-> !core_sel_pll)
    else $error("safe mode switched without command");
endmodule : clock_mode_checker
bind clock_mode_sleep_controller clock_mode_checker chk (
  .ref_clk(ref_clk), .reset(reset), .operating_strap(operating_strap),
  .safe_operation_strap(safe_operation_strap), .host_sel(host_sel), .sleep_req(sleep_req),
  .pll_lock(pll_lock), .spi_slave_busy(spi_slave_busy), .spi_master_busy(spi_master_busy),
  .manual_pll_sel(manual_pll_sel), .pll_mult(pll_mult), .pll_enable(pll_enable),
  .div_enable(div_enable), .core_sel_pll(core_sel_pll), .core_clk_en(core_clk_en),
  .pcie_clk_en(pcie_clk_en), .spi_slave_clk_en(spi_slave_clk_en),
  .spi_master_clk_en(spi_master_clk_en), .pcie_host_active(pcie_host_active),
  .spi_host_active(spi_host_active), .lock_status(lock_status), .sleep_active(sleep_active)
);
`default_nettype wire

// ==== tb/clock_mode_sleep_controller_tb.sv ====
// testbench: normal switch-over, host gating, sleep, safe mode
// assumes the checker is bound through its own file
`timescale 1ns/1ps
`default_nettype none
module clock_mode_sleep_controller_tb;
  import clock_mode_pkg::*;
  logic ref_clk = 0, reset = 1, operating_strap = 0, safe_operation_strap = 0, host_sel = 1;
  logic sleep_req = 0, pll_lock = 0, spi_slave_busy = 0, spi_master_busy = 0;
  logic host_revert = 0; // partner: drop the pll command
  wire logic manual_pll_sel;
  logic [PLL_MULT_W-1:0] pll_mult;
  logic pll_enable, div_enable, core_sel_pll, core_clk_en, pcie_clk_en, spi_slave_clk_en;
  logic spi_master_clk_en, pcie_host_active, spi_host_active, lock_status, sleep_active;
  int num_errors = 0, num_checks = 0;
  initial forever #4 ref_clk = ~ref_clk;
  clock_mode_sleep_controller DUT (
    .ref_clk(ref_clk), .reset(reset), .operating_strap(operating_strap),
    .safe_operation_strap(safe_operation_strap), .host_sel(host_sel), .sleep_req(sleep_req),
    .pll_lock(pll_lock), .spi_slave_busy(spi_slave_busy), .spi_master_busy(spi_master_busy),
    .manual_pll_sel(manual_pll_sel), .pll_mult(pll_mult), .pll_enable(pll_enable),
    .div_enable(div_enable), .core_sel_pll(core_sel_pll), .core_clk_en(core_clk_en),
    .pcie_clk_en(pcie_clk_en), .spi_slave_clk_en(spi_slave_clk_en),
    .spi_master_clk_en(spi_master_clk_en), .pcie_host_active(pcie_host_active),
    .spi_host_active(spi_host_active), .lock_status(lock_status), .sleep_active(sleep_active)
  );
  host_board_model host (.ref_clk(ref_clk), .reset(reset), .safe_mode(safe_operation_strap),
    .lock_status(lock_status), .host_revert(host_revert), .manual_pll_sel(manual_pll_sel));
  // ==========================================================
  // shared tasks
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // bounded wait for an output to go high: 0 pll select, 1 asleep, 2 lock
  task wait_for(input int sel);
    int n;
    logic v;
    for (n = 0; n < 300; n++) begin
      cyc(1);
      v = (sel == 0) ? core_sel_pll : (sel == 1) ? sleep_active : lock_status;
      if (v === 1'h1) return;
    end
    check(8'h0, 8'h1);
    tally_and_finish;
  endtask : wait_for
  task do_reset(input logic safe, input logic op);
    @(posedge ref_clk);
    reset <= 1'h1;
    pll_lock <= 1'h0;
    host_revert <= 1'h0;
    safe_operation_strap <= safe;
    operating_strap <= op;
    repeat (12) @(posedge ref_clk);
    reset <= 1'h0;
  endtask : do_reset
  // ==========================================================
  // main sequence
  initial begin
    do_reset(1'h0, 1'h0);
    cyc(20);
    check(pll_mult, 8'h10);
    check(core_sel_pll, 1'h0);
    check({pcie_clk_en, spi_slave_clk_en, pcie_host_active, spi_host_active}, 4'hA);
    @(posedge ref_clk) pll_lock <= 1'h1;
    wait_for(0);
    check(lock_status, 1'h1);
    @(posedge ref_clk) host_sel <= 1'h0;
    cyc(2);
    check({pcie_clk_en, spi_slave_clk_en, pcie_host_active, spi_host_active}, 4'h5);
    $display("test normal done");
    @(posedge ref_clk);
    host_sel <= 1'h1;
    spi_master_busy <= 1'h1;
    spi_slave_busy <= 1'h1;
    sleep_req <= 1'h1;
    cyc(10);
    @(posedge ref_clk) spi_master_busy <= 1'h0;
    cyc(5);
    check(sleep_active, 1'h0);
    @(posedge ref_clk) spi_slave_busy <= 1'h0;
    wait_for(1);
    check({core_clk_en, spi_slave_clk_en, spi_master_clk_en, pcie_clk_en}, 4'h1);
    check(pll_enable & div_enable, 1'h1);
    @(posedge ref_clk) sleep_req <= 1'h0;
    cyc(2);
    check({sleep_active, core_clk_en, spi_master_clk_en, core_sel_pll}, 4'h7);
    $display("test sleep done");
    do_reset(1'h1, 1'h0);
    cyc(20);
    check({pcie_clk_en, spi_slave_clk_en, core_sel_pll}, 3'h6);
    @(posedge ref_clk) pll_lock <= 1'h1;
    wait_for(2);
    check(core_sel_pll, 1'h0);
    wait_for(0);
    check(manual_pll_sel, 1'h1);
    // safe mode sleep keeps pcie clocked and brings the pll clock back
    @(posedge ref_clk) sleep_req <= 1'h1;
    wait_for(1);
    check({pcie_clk_en, spi_slave_clk_en, core_clk_en, core_sel_pll}, 4'h9);
    @(posedge ref_clk) sleep_req <= 1'h0;
    cyc(2);
    check({sleep_active, spi_slave_clk_en, core_sel_pll}, 3'h3);
    // host drops its command: core goes back to the reference clock
    @(posedge ref_clk) host_revert <= 1'h1;
    cyc(3);
    check(core_sel_pll, 1'h0);
    $display("test safe done");
    // strap for a non-normal mode: lock alone must not switch the core
    do_reset(1'h0, 1'h1);
    @(posedge ref_clk) pll_lock <= 1'h1;
    wait_for(2);
    cyc(2);
    check(core_sel_pll, 1'h0);
    $display("test strap done");
    tally_and_finish;
  end
endmodule : clock_mode_sleep_controller_tb
`default_nettype wire

// ==== tb/host_board_model.sv ====
// partner: board host that, in safe mode, polls lock and commands the pll clock
// assumes lock_status is synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
  input wire logic ref_clk, // control clock
  input wire logic reset, // synchronous, active high
  input wire logic safe_mode, // safe strap as fitted
  input wire logic lock_status, // polled lock flag
  input wire logic host_revert, // host asks for the reference clock back
  output logic manual_pll_sel // pll clock command
);
  // poll every cycle; command the switch once lock is seen, drop it on request
  always_ff @(posedge ref_clk) begin
    if (reset) manual_pll_sel <= 1'h0;
    else if (host_revert) manual_pll_sel <= 1'h0;
    else if (safe_mode && lock_status) manual_pll_sel <= 1'h1;
  end
endmodule : host_board_model
`default_nettype wire
